// file: pkg/led_matrix_pkg.sv
// Package: constants and carriers for the matrix LED driver serial port
package led_matrix_pkg;
  localparam int WORD_BITS      = 16;
  localparam int ADDR_MSB       = 14;
  localparam int ADDR_LSB       = 8;
  localparam int RW_BIT         = 15;
  localparam logic [6:0] ADDR_NOP = 7'h00;
  localparam int FONT_ENTRIES   = 128;
  localparam int FONT_FIXED     = 104;
  localparam int FONT_USER      = 24;
  localparam int GLYPH_COLS     = 5;
  localparam int ROW_SINKS      = 14;
  localparam int COL_SOURCES    = 10;
  // Register indices inside the block (address codes)
  localparam logic [6:0] ADDR_CONFIG    = 7'h04;
  localparam logic [6:0] ADDR_USER_PTR  = 7'h05;
  localparam logic [6:0] ADDR_USER_DATA = 7'h06;
  localparam logic [6:0] ADDR_DIGIT0    = 7'h20;
  localparam int NUM_DIGITS     = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int CFG_BICOLOR    = 1;
  localparam int CFG_RUN        = 0;
  // Mux clock and blink timing
  localparam int MUX_PER_SLOT   = 64;
  localparam int BLINK_HALF_SLOTS = 2048;
  localparam int USER_BYTES     = FONT_USER * GLYPH_COLS;

  typedef struct packed {
    logic       read;
    logic [6:0] addr;
    logic [7:0] data;
  } cmd_s;

  typedef struct packed {
    logic [ROW_SINKS-1:0]   rowSinkOn;
    logic [COL_SOURCES-1:0] colSourceOn;
  } drive_s;
endpackage

// file: design/matrix_led_driver_serial_port.sv
// Serial command port, glyph store and multiplex scan of the matrix LED driver
// What this block does
// - Serial data shifts into a 16-bit register on each rising serial clock edge.
// - Serial clock is ignored unless chip select is low.
// - Each captured bit reappears on serial out 15.5 clocks later.
// - Serial out changes on the falling clock edge, stable at next rise.
// - Serial input is sampled at the rising clock edge.
// - Chip select rise latches the last 16 shifted bits as command word.
// - Serial out is always driven, never high impedance.
// - Font map has 128 entries: 104 fixed, 24 user-definable.
// - User glyphs load only over the serial port, held in volatile storage.
// - Scan drives four single-colour digits or two two-colour digits.
// - Multiplex scan is timed from the multiplex clock input.
// - Blink timing appears as a square wave on an open-drain output.
// - Outputs 0-13 sink rows, outputs 14-23 source columns.
// - Command is 16 bits MSB first: read bit, 7-bit address, data byte.
// - Any bit count per frame keeps only the last 16 bits.
// - A read loads the addressed register into the low byte at chip select rise.
// - Address 0x00 is a no-operation.
`timescale 1ns/1ps
`default_nettype none
module matrix_led_driver_serial_port
  import led_matrix_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  input  wire logic                       clkEn,
  input  wire logic                       csn,
  input  wire logic                       serialClk,
  input  wire logic                       serialIn,
  input  wire logic                       mux_clock_in,
  output var  logic                       serialOut,
  output var  logic                       serialOutEn,
  output var  logic                       blinkOut,
  output var  logic                       blinkOutEn,
  output var  logic [ROW_SINKS-1:0]       row_cathode_sinks,
  output var  logic [COL_SOURCES-1:0]     column_anode_sources,
  output var  led_matrix_pkg::cmd_s       lastCmd,
  output var  logic                       cmdStrobe
);
  import led_matrix_pkg::*;

  // Shift path and font split are built for these sizes only
  if (WORD_BITS != 16 || FONT_FIXED + FONT_USER != FONT_ENTRIES) begin : g_bad_size
    $error("Unsupported word or font size");
  end

  // Two-flop synchronisers; first stage read only by the second
  logic [2:0] syncA;
  logic [2:0] syncB;
  logic [2:0] pinNow;
  logic [2:0] pinPrev;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncA   <= 3'h7;
      syncB   <= 3'h7;
      pinPrev <= 3'h7;
    end else if (clkEn) begin
      syncA   <= {csn, serialClk, mux_clock_in};
      syncB   <= syncA;
      pinPrev <= syncB;
    end
  end
  assign pinNow = syncB;

  logic csLow;
  logic sclkRise;
  logic sclkFall;
  logic csRise;
  logic muxRise;
  logic dinSync;
  logic dinMeta;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dinMeta <= 1'b0;
      dinSync <= 1'b0;
    end else if (clkEn) begin
      dinMeta <= serialIn;
      dinSync <= dinMeta;
    end
  end
  assign csLow    = ~pinNow[2];
  assign sclkRise = csLow & pinNow[1] & ~pinPrev[1];
  assign sclkFall = csLow & ~pinNow[1] & pinPrev[1];
  assign csRise   = pinNow[2] & ~pinPrev[2];
  assign muxRise  = pinNow[0] & ~pinPrev[0];

  // Serial shift path
  logic [WORD_BITS-1:0] shiftReg;
  logic [WORD_BITS-1:0] next_shiftReg;
  logic                 next_serialOut;
  cmd_s                 next_lastCmd;
  logic                 next_cmdStrobe;

  // Register file
  logic [7:0] displayCfg;
  logic [7:0] next_config;
  logic [6:0] userPtr;
  logic [6:0] next_userPtr;
  logic [7:0] digitCode [NUM_DIGITS];
  logic [7:0] next_digitCode [NUM_DIGITS];
  logic [GLYPH_COLS*7-1:0] userGlyph [FONT_USER];
  logic                    userWe;
  logic [4:0]              userIdx;
  logic [2:0]              userCol;

  function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] cfg,
                                          input logic [6:0] ptr);
    read_reg = 8'h00;
    if (a == ADDR_CONFIG) begin
      read_reg = cfg;
    end else if (a == ADDR_USER_PTR) begin
      read_reg = {1'b0, ptr};
    end
  endfunction

  function automatic logic is_digit(input logic [6:0] a);
    is_digit = (a >= ADDR_DIGIT0) && (a < ADDR_DIGIT0 + 7'(NUM_DIGITS));
  endfunction

  always_comb begin
    cmd_s c;
    c              = cmd_s'(shiftReg);
    next_shiftReg  = shiftReg;
    next_serialOut = serialOut;
    next_lastCmd   = lastCmd;
    next_cmdStrobe = 1'b0;
    next_config    = displayCfg;
    next_userPtr   = userPtr;
    userWe         = 1'b0;
    userIdx        = 5'(userPtr / 7'(GLYPH_COLS));
    userCol        = 3'(userPtr % 7'(GLYPH_COLS));
    for (int d = 0; d < NUM_DIGITS; d++) begin
      next_digitCode[d] = digitCode[d];
    end
    if (sclkRise) begin
      next_shiftReg = {shiftReg[WORD_BITS-2:0], dinSync};
    end
    if (sclkFall) begin
      next_serialOut = shiftReg[WORD_BITS-1];
    end
    if (csRise) begin
      next_lastCmd   = c;
      next_cmdStrobe = 1'b1;
      if (c.read) begin
        next_shiftReg[7:0] = read_reg(c.addr, displayCfg, userPtr);
        if (is_digit(c.addr)) begin
          next_shiftReg[7:0] = digitCode[2'(c.addr - ADDR_DIGIT0)];
        end
      end else if (c.addr == ADDR_NOP) begin
        next_shiftReg = shiftReg;
      end else if (c.addr == ADDR_CONFIG) begin
        next_config = c.data;
      end else if (c.addr == ADDR_USER_PTR) begin
        next_userPtr = 7'(c.data);
      end else if (c.addr == ADDR_USER_DATA) begin
        if (userPtr < 7'(USER_BYTES)) begin
          userWe       = 1'b1;
          next_userPtr = userPtr + 7'h01;
        end
      end else if (is_digit(c.addr)) begin
        next_digitCode[2'(c.addr - ADDR_DIGIT0)] = c.data;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shiftReg  <= '0;
      serialOut <= 1'b0;
      lastCmd   <= '0;
      cmdStrobe <= 1'b0;
      displayCfg <= CONFIG_RESET;
      userPtr   <= '0;
      for (int d = 0; d < NUM_DIGITS; d++) begin
        digitCode[d] <= 8'h00;
      end
    end else if (clkEn) begin
      shiftReg  <= next_shiftReg;
      serialOut <= next_serialOut;
      lastCmd   <= next_lastCmd;
      cmdStrobe <= next_cmdStrobe;
      displayCfg <= next_config;
      userPtr   <= next_userPtr;
      for (int d = 0; d < NUM_DIGITS; d++) begin
        digitCode[d] <= next_digitCode[d];
      end
    end
  end

  // Volatile glyph store; no reset, contents are undefined at power-up
  always_ff @(posedge mclk) begin
    if (clkEn && userWe) begin
      userGlyph[userIdx][userCol*7 +: 7] <= next_lastCmd.data[6:0];
    end
  end

  // Fixed glyphs: a compact generated pattern stands in for the real font
  function automatic logic [6:0] fixed_col(input logic [6:0] code, input logic [2:0] col);
    fixed_col = code ^ {4'h0, col};
  endfunction

  logic [6:0] glyphCol;
  logic [6:0] activeCode;
  logic [1:0] scanDigit;
  logic [2:0] scanCol;
  logic [6:0] muxDiv;
  logic [11:0] blinkDiv;
  logic        blinkPhase;
  logic [1:0]  next_scanDigit;
  logic [2:0]  next_scanCol;
  logic [6:0]  next_muxDiv;
  logic [11:0] next_blinkDiv;
  logic        next_blinkPhase;
  drive_s      drive;

  always_comb begin
    activeCode = digitCode[scanDigit][6:0];
    if (activeCode >= 7'(FONT_FIXED)) begin
      glyphCol = userGlyph[5'(activeCode - 7'(FONT_FIXED))][scanCol*7 +: 7];
    end else begin
      glyphCol = fixed_col(activeCode, scanCol);
    end
  end

  always_comb begin
    next_muxDiv     = muxDiv;
    next_scanCol    = scanCol;
    next_scanDigit  = scanDigit;
    next_blinkDiv   = blinkDiv;
    next_blinkPhase = blinkPhase;
    if (muxRise) begin
      next_muxDiv = muxDiv + 7'h01;
      if (muxDiv == 7'(MUX_PER_SLOT - 1)) begin
        next_muxDiv = '0;
        next_blinkDiv = blinkDiv + 12'h001;
        if (blinkDiv == 12'(BLINK_HALF_SLOTS - 1)) begin
          next_blinkDiv   = '0;
          next_blinkPhase = ~blinkPhase;
        end
        if (scanCol == 3'(GLYPH_COLS - 1)) begin
          next_scanCol = '0;
          next_scanDigit = displayCfg[CFG_BICOLOR] ? {1'b0, ~scanDigit[0]} : scanDigit + 2'h1;
        end else begin
          next_scanCol = scanCol + 3'h1;
        end
      end
    end
  end

  always_comb begin
    drive = '0;
    if (displayCfg[CFG_RUN]) begin
      if (displayCfg[CFG_BICOLOR]) begin
        drive.rowSinkOn[scanDigit[0]*7 +: 7] = glyphCol;
        drive.colSourceOn[scanCol] = 1'b1;
        // Index in int width: a 3-bit sum would wrap past column 7
        drive.colSourceOn[int'(scanCol) + GLYPH_COLS] = 1'b1;
      end else begin
        drive.rowSinkOn[scanDigit[1]*7 +: 7] = glyphCol;
        drive.colSourceOn[scanDigit[0]*GLYPH_COLS + scanCol] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      muxDiv               <= '0;
      scanCol              <= '0;
      scanDigit            <= '0;
      blinkDiv             <= '0;
      blinkPhase           <= 1'b0;
      blinkOut             <= 1'b0;
      blinkOutEn           <= 1'b0;
      serialOutEn          <= 1'b1;
      row_cathode_sinks    <= '0;
      column_anode_sources <= '0;
    end else if (clkEn) begin
      muxDiv               <= next_muxDiv;
      scanCol              <= next_scanCol;
      scanDigit            <= next_scanDigit;
      blinkDiv             <= next_blinkDiv;
      blinkPhase           <= next_blinkPhase;
      blinkOut             <= 1'b0;
      blinkOutEn           <= ~next_blinkPhase;
      serialOutEn          <= 1'b1;
      row_cathode_sinks    <= drive.rowSinkOn;
      column_anode_sources <= drive.colSourceOn;
    end
  end
endmodule // matrix_led_driver_serial_port
`default_nettype wire

// file: verification/spi_master_model.sv
// Serial bus master model driving the matrix driver command port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic mclk,
  output var  logic csn,
  output var  logic serialClk,
  output var  logic serialIn,
  input  wire logic serialOut
);
  // 62.5 ns half period gives the 125 ns link clock, well above what the synchronisers need
  localparam real HALF = 62.5;
  initial begin
    csn = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] got);
    got = '0;
    @(negedge mclk);
    csn = 1'b0;
    #(HALF);
    for (int k = n - 1; k >= 0; k--) begin
      serialClk = 1'b0;
      serialIn = w[k];
      #(HALF);
      got[k] = serialOut;
      serialClk = 1'b1;
      #(HALF);
    end
    csn = 1'b1;
    #(HALF);
    serialClk = 1'b0;
    // Released data line shows the inverse, not a stale value
    serialIn = ~serialIn;
    #(HALF);
  endtask
  task automatic idleClocks(input int n);
    for (int k = 0; k < 2 * n; k++) begin
      serialClk = ~serialClk;
      serialIn = ~serialIn;
      #(HALF);
    end
  endtask
endmodule // spi_master_model
`default_nettype wire

// file: verification/matrix_led_driver_serial_port_properties.sv
// Checker for the matrix driver serial port pins
`timescale 1ns/1ps
`default_nettype none
module matrix_led_driver_serial_port_properties
  import led_matrix_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 csn,
  input wire logic                 serialClk,
  input wire logic                 serialOut,
  input wire logic                 serialOutEn,
  input wire logic                 blinkOut,
  input wire led_matrix_pkg::cmd_s lastCmd,
  input wire logic                 cmdStrobe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_out_driven:
    assert property (serialOutEn) else $error("serial out released");
  a_blink_drain:
    assert property (blinkOut == 1'b0) else $error("blink drives high");
  a_strobe_single:
    assert property (cmdStrobe |=> !cmdStrobe) else $error("strobe too long");
  a_latch_on_rise:
    assert property ($rose(csn) |-> ##[1:5] cmdStrobe) else $error("no latch after select rise");
  a_strobe_deselected:
    assert property (cmdStrobe |-> csn && $past(csn, 2)) else $error("strobe while selected");
  a_quiet_idle:
    assert property (csn [*6] |=> !cmdStrobe) else $error("strobe while idle");
  a_out_on_fall:
    assert property ($changed(serialOut) |-> !$past(serialClk) && !$past(serialClk, 2))
      else $error("serial out moved off falling edge");
  a_cmd_hold:
    assert property (!cmdStrobe |-> $stable(lastCmd)) else $error("word changed without strobe");
endmodule // matrix_led_driver_serial_port_properties
bind matrix_led_driver_serial_port matrix_led_driver_serial_port_properties matrix_led_driver_serial_port_properties_i (
  .mclk(mclk), .resetn(resetn), .csn(csn), .serialClk(serialClk), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .blinkOut(blinkOut), .lastCmd(lastCmd), .cmdStrobe(cmdStrobe));
`default_nettype wire

// file: verification/matrix_led_driver_serial_port_bench.sv
// Self-checking bench for the matrix driver serial port
`timescale 1ns/1ps
`default_nettype none
module matrix_led_driver_serial_port_bench;
  import led_matrix_pkg::*;
  logic                   mclk = 1'b0;
  logic                   resetn = 1'b0;
  logic                   muxClockIn = 1'b0;
  logic                   csn, serialClk, serialIn, serialOut, serialOutEn, blinkOut, blinkOutEn, cmdStrobe;
  logic [ROW_SINKS-1:0]   rows;
  logic [COL_SOURCES-1:0] cols;
  cmd_s                   lastCmd;
  logic [15:0]            sr = '0;
  logic [7:0]             regs [128];
  cmd_s                   cmdQ [$];
  logic [15:0]            cmds [7] = '{16'h8400, 16'h005a, 16'h2141, 16'ha100, 16'h9000, 16'h0000, 16'h2141};
  int                     mismatches = 0;
  int                     comparisons = 0;
  always #5 mclk = ~mclk;
  always begin
    repeat (8) @(negedge mclk);
    muxClockIn = ~muxClockIn;
  end
  matrix_led_driver_serial_port matrix_led_driver_serial_port_i (
    .mclk(mclk), .resetn(resetn), .clkEn(1'b1), .csn(csn), .serialClk(serialClk), .serialIn(serialIn),
    .mux_clock_in(muxClockIn), .serialOut(serialOut), .serialOutEn(serialOutEn), .blinkOut(blinkOut),
    .blinkOutEn(blinkOutEn), .row_cathode_sinks(rows), .column_anode_sources(cols), .lastCmd(lastCmd),
    .cmdStrobe(cmdStrobe));
  spi_master_model spi_master_model_i (
    .mclk(mclk), .csn(csn), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // First rise of a frame shows a bit from before the frame, so it is masked
  task automatic frame(input logic [31:0] w, input int n);
    logic [31:0] got;
    logic [31:0] want;
    logic [31:0] m;
    cmd_s c;
    want = '0;
    m = (32'h1 << (n - 1)) - 32'h1;
    for (int k = n - 1; k >= 0; k--) begin
      want[k] = sr[15];
      sr = {sr[14:0], w[k]};
    end
    c = sr;
    cmdQ.push_back(c);
    spi_master_model_i.xfer(w, n, got);
    check(got & m, want & m);
    if (c.read) sr[7:0] = regs[c.addr];
    else if (c.addr == ADDR_CONFIG || c.addr[6:2] == ADDR_DIGIT0[6:2]) regs[c.addr] = c.data;
  endtask
  // Looked at on the falling edge, clear of the edge that launches the strobe
  always @(negedge mclk) begin
    if (cmdStrobe === 1'b1) begin
      if (cmdQ.size() == 0) check(32'(lastCmd), 32'hffffffff);
      else check(32'(lastCmd), 32'(cmdQ.pop_front()));
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    summarize();
  end
  initial begin
    void'($urandom(72898));
    foreach (regs[i]) regs[i] = '0;
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    // Synchronisers settle for a few edges before the first frame
    repeat (3) @(negedge mclk);
    frame({16'($urandom), 1'b0, ADDR_CONFIG, 8'h03}, 32);
    foreach (cmds[i]) frame({16'h0, cmds[i]}, 16);
    frame({16'h0, 1'b0, ADDR_USER_PTR, 8'h00}, 16);
    repeat (GLYPH_COLS) frame({16'h0, 1'b0, ADDR_USER_DATA, 8'h55}, 16);
    frame({16'h0, 1'b0, ADDR_DIGIT0, 8'(FONT_FIXED)}, 16);
    spi_master_model_i.idleClocks(8);
    frame({24'h0, 8'($urandom)}, 8);
    frame(32'h8400, 16);
    frame({24'h0, 8'($urandom)}, 16);
    repeat (20) @(negedge mclk);
    check(32'(cmdQ.size()), 32'h0);
    check(32'(serialOutEn), 32'h1);
    check(32'(blinkOutEn), 32'h1);
    check(32'($countones(cols)), regs[ADDR_CONFIG][CFG_BICOLOR] ? 32'h2 : 32'h1);
    check(32'(cols[9:5]), 32'(cols[4:0]));
    check(32'(rows[6:0] == 7'h55 || (rows[6:0] == 7'h00 && rows[13:7] != 7'h00)), 32'h1);
    summarize();
  end
endmodule // matrix_led_driver_serial_port_bench
`default_nettype wire
